// ---- src/idx_exec.sv ----
// Operation
// - decrement register, result to acc or reg, Z
// - decrement-skip writes result, flags untouched
// - zero result discards next instruction, two cycles
// - jump loads nine-bit immediate into pc[8:0]
// - jump loads pc[10:9] from status page bits
// - jump takes two cycles, flags untouched
// - increment register, result to acc or reg, Z
// - increment-skip writes result, flags untouched
// - zero result discards next instruction, two cycles
// - or literal into acc, update Z
// - or register into acc or reg, Z
`timescale 1ns/10ps
`default_nettype none
module idx_exec
  import idx_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic ISSUE,
  input wire idx_instr_t INSTR,
  input wire logic [7:0] FILE_DATA,
  input wire logic [7:0] STATUS_IN,
  input wire logic [7:0] ACC_IN,
  output logic [7:0] ACC,
  output logic ACC_WE,
  output idx_wb_t FILE_WB,
  output logic Z_WE,
  output logic Z_VAL,
  output logic [10:0] PC_LOAD,
  output logic PC_WE,
  output logic FLUSH
);

  logic [7:0] acc_reg, acc_next;
  logic acc_we_reg, acc_we_next;
  idx_wb_t wb_reg, wb_next;
  logic z_we_reg, z_we_next;
  logic z_val_reg, z_val_next;
  logic [10:0] pc_reg, pc_next;
  logic pc_we_reg, pc_we_next;
  logic flush_reg, flush_next;
  logic [7:0] res;
  logic to_reg;
  logic sets_z;

  // one clock domain, so every check below shares clock and reset
  default clocking idx_cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // result path; adds and subtracts drop the carry to wrap
  always_comb
  begin
    res = IDX_ZERO;
    to_reg = 1'b0;
    sets_z = 1'b0;
    case (INSTR.op)
      IDX_DEC_REG:
      begin
        res = FILE_DATA - IDX_ONE;
        to_reg = INSTR.dest_f;
        sets_z = 1'b1;
      end
      IDX_DEC_SKIP:
      begin
        res = FILE_DATA - IDX_ONE;
        to_reg = INSTR.dest_f;
      end
      IDX_INC_REG:
      begin
        res = FILE_DATA + IDX_ONE;
        to_reg = INSTR.dest_f;
        sets_z = 1'b1;
      end
      IDX_INC_SKIP:
      begin
        res = FILE_DATA + IDX_ONE;
        to_reg = INSTR.dest_f;
      end
      IDX_OR_LIT:
      begin
        res = ACC_IN | INSTR.imm[IDX_DW-1:0];
        sets_z = 1'b1;
      end
      IDX_OR_REG:
      begin
        res = ACC_IN | FILE_DATA;
        to_reg = INSTR.dest_f;
        sets_z = 1'b1;
      end
      default:
      begin
        res = IDX_ZERO;
      end
    endcase
  end

  // next-state of all outputs; strobes last one cycle per issue
  always_comb
  begin
    acc_next = acc_reg;
    acc_we_next = 1'b0;
    wb_next = '{we: 1'b0, addr: INSTR.addr, data: res};
    z_we_next = 1'b0;
    z_val_next = z_val_reg;
    pc_next = pc_reg;
    pc_we_next = 1'b0;
    flush_next = 1'b0;
    if (ISSUE)
    begin
      if (INSTR.op == IDX_JUMP)
      begin
        // page bits ride in from status, no flag write
        pc_next = {STATUS_IN[IDX_PAGE_HI:IDX_PAGE_LO],
                   INSTR.imm};
        pc_we_next = 1'b1;
        flush_next = 1'b1;
      end
      else if (INSTR.op != IDX_NOP)
      begin
        if (to_reg)
          wb_next.we = 1'b1;
        else
        begin
          acc_next = res;
          acc_we_next = 1'b1;
        end
        if (sets_z)
        begin
          z_we_next = 1'b1;
          z_val_next = (res == IDX_ZERO);
        end
        // prefetched word is dropped as a nop on zero result
        if ((INSTR.op == IDX_DEC_SKIP || INSTR.op == IDX_INC_SKIP)
            && res == IDX_ZERO)
          flush_next = 1'b1;
      end
    end
  end

  // register stage; every output comes from here
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      acc_reg <= IDX_ZERO;
      acc_we_reg <= 1'b0;
      wb_reg <= '0;
      z_we_reg <= 1'b0;
      z_val_reg <= 1'b0;
      pc_reg <= IDX_PC_RST;
      pc_we_reg <= 1'b0;
      flush_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      acc_we_reg <= acc_we_next;
      wb_reg <= wb_next;
      z_we_reg <= z_we_next;
      z_val_reg <= z_val_next;
      pc_reg <= pc_next;
      pc_we_reg <= pc_we_next;
      flush_reg <= flush_next;
    end
  end

  assign ACC = acc_reg;
  assign ACC_WE = acc_we_reg;
  assign FILE_WB = wb_reg;
  assign Z_WE = z_we_reg;
  assign Z_VAL = z_val_reg;
  assign PC_LOAD = pc_reg;
  assign PC_WE = pc_we_reg;
  assign FLUSH = flush_reg;

  sequence skip_zero_s;
    ISSUE && (INSTR.op == IDX_DEC_SKIP || INSTR.op == IDX_INC_SKIP)
      && res == IDX_ZERO;
  endsequence

  sequence jump_s;
    ISSUE && INSTR.op == IDX_JUMP;
  endsequence

  dec_result_a: assert property (
    ISSUE && INSTR.op == IDX_DEC_REG && !INSTR.dest_f |=>
      ACC_WE && ACC == $past(FILE_DATA) - IDX_ONE && Z_WE
      && Z_VAL == ($past(FILE_DATA) == IDX_ONE))
    else $error("decrement result wrong");
  dec_skip_a: assert property (
    ISSUE && INSTR.op == IDX_DEC_SKIP |=> !Z_WE
      && FILE_WB.data == $past(FILE_DATA) - IDX_ONE)
    else $error("decrement-skip touched flags");
  skip_flush_a: assert property (
    skip_zero_s |=> FLUSH)
    else $error("zero skip did not flush");
  jump_low_a: assert property (
    jump_s |=> PC_WE && PC_LOAD[IDX_JW-1:0] == $past(INSTR.imm))
    else $error("jump target wrong");
  jump_page_a: assert property (
    jump_s |=> PC_LOAD[IDX_PCW-1:IDX_JW] ==
      $past(STATUS_IN[IDX_PAGE_HI:IDX_PAGE_LO]))
    else $error("jump page wrong");
  jump_flags_a: assert property (
    jump_s |=> FLUSH && !Z_WE && !ACC_WE && !FILE_WB.we)
    else $error("jump timing or flags wrong");
  inc_wb_a: assert property (
    ISSUE && INSTR.op == IDX_INC_REG && INSTR.dest_f |=>
      FILE_WB.we && FILE_WB.data == $past(FILE_DATA) + IDX_ONE)
    else $error("increment writeback wrong");
  inc_skip_a: assert property (
    ISSUE && INSTR.op == IDX_INC_SKIP |=> !Z_WE
      && ACC_WE == !$past(INSTR.dest_f)
      && FILE_WB.data == $past(FILE_DATA) + IDX_ONE)
    else $error("increment-skip result or flags wrong");
  noskip_a: assert property (
    ISSUE && INSTR.op == IDX_INC_SKIP && res != IDX_ZERO |=>
      !FLUSH && !Z_WE)
    else $error("nonzero increment-skip flushed");
  or_lit_a: assert property (
    ISSUE && INSTR.op == IDX_OR_LIT |=> ACC_WE && !FILE_WB.we && Z_WE
      && ACC == ($past(ACC_IN) | $past(INSTR.imm[IDX_DW-1:0])))
    else $error("or literal result wrong");
  or_reg_a: assert property (
    ISSUE && INSTR.op == IDX_OR_REG |=> Z_WE
      && FILE_WB.we == $past(INSTR.dest_f)
      && FILE_WB.data == ($past(ACC_IN) | $past(FILE_DATA)))
    else $error("or register result wrong");
  zero_flag_a: assert property (
    Z_WE |-> Z_VAL == ((ACC_WE ? ACC : FILE_WB.data) == IDX_ZERO))
    else $error("zero flag mismatch");
endmodule
`default_nettype wire

// ---- src/idx_pkg.sv ----
package idx_pkg;
  // operation select for one issued instruction
  typedef enum logic [2:0] {
    IDX_NOP,
    IDX_DEC_REG,
    IDX_DEC_SKIP,
    IDX_INC_REG,
    IDX_INC_SKIP,
    IDX_OR_LIT,
    IDX_OR_REG,
    IDX_JUMP
  } idx_op_t;

  localparam int IDX_DW = 8;
  localparam int IDX_AW = 5;
  localparam int IDX_PCW = 11;
  localparam int IDX_JW = 9;
  localparam int IDX_PAGE_LO = 5;
  localparam int IDX_PAGE_HI = 6;
  localparam logic [7:0] IDX_ONE = 8'h01;
  localparam logic [7:0] IDX_ZERO = 8'h00;
  localparam logic [10:0] IDX_PC_RST = 11'h000;

  // one issued instruction with its operands
  typedef struct packed {
    idx_op_t op;
    logic dest_f;
    logic [4:0] addr;
    logic [8:0] imm;
  } idx_instr_t;

  // result written back to the register file
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } idx_wb_t;
endpackage

// ---- tb/idx_exec_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module idx_exec_tb;
  import idx_pkg::*;
  logic MCLK, RSTN, ISSUE, ACC_WE, Z_WE, Z_VAL, PC_WE, FLUSH;
  idx_instr_t INSTR;
  idx_wb_t FILE_WB;
  logic [7:0] FILE_DATA, STATUS_IN, ACC_IN, ACC;
  logic [10:0] PC_LOAD;
  logic [31:0] lfsr;
  int n_mismatch, num_checks;

  idx_exec dut (.MCLK(MCLK), .RSTN(RSTN), .ISSUE(ISSUE), .INSTR(INSTR),
    .FILE_DATA(FILE_DATA), .STATUS_IN(STATUS_IN), .ACC_IN(ACC_IN),
    .ACC(ACC), .ACC_WE(ACC_WE), .FILE_WB(FILE_WB), .Z_WE(Z_WE),
    .Z_VAL(Z_VAL), .PC_LOAD(PC_LOAD), .PC_WE(PC_WE), .FLUSH(FLUSH));

  // 20 MHz core clock
  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected 8-bit result, wrapping like the hardware word
  function automatic logic [7:0] exp_res(idx_op_t op, logic [8:0] k,
    logic [7:0] fd, logic [7:0] w);
    case (op)
      IDX_DEC_REG, IDX_DEC_SKIP: return fd - IDX_ONE;
      IDX_INC_REG, IDX_INC_SKIP: return fd + IDX_ONE;
      IDX_OR_LIT: return w | k[7:0];
      default: return w | fd;
    endcase
  endfunction

  // wide enough for address and data together
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // issue one instruction at a falling edge, check strobes one cycle on;
  // no reissue after a flush so the nop slot stays quiet
  task automatic run(idx_op_t op, logic d, logic [4:0] a, logic [8:0] k,
    logic [7:0] fd, logic [7:0] st, logic [7:0] w);
    logic [7:0] r;
    logic jp, lt, sk, aw, fw, zw, fl;
    r = exp_res(op, k, fd, w);
    jp = (op == IDX_JUMP);
    lt = (op == IDX_OR_LIT);
    sk = (op == IDX_DEC_SKIP) || (op == IDX_INC_SKIP);
    aw = !jp && (lt || !d);
    fw = !jp && !lt && d;
    zw = !jp && !sk;
    fl = jp || (sk && r == IDX_ZERO);
    ISSUE = 1'b1;
    INSTR = '{op, d, a, k};
    FILE_DATA = fd;
    STATUS_IN = st;
    ACC_IN = w;
    @(negedge MCLK);
    chk("ACC_WE", aw, ACC_WE);
    chk("FILE_WB.we", fw, FILE_WB.we);
    chk("Z_WE", zw, Z_WE);
    chk("FLUSH", fl, FLUSH);
    chk("PC_WE", jp, PC_WE);
    if (aw)
      chk("ACC", r, ACC);
    if (fw)
      chk("FILE_WB", {a, r}, {FILE_WB.addr, FILE_WB.data});
    if (zw)
      chk("Z_VAL", r == IDX_ZERO, Z_VAL);
    if (jp)
      chk("PC_LOAD", {st[6:5], k}, PC_LOAD);
    if (fl)
    begin
      ISSUE = 1'b0;
      @(negedge MCLK);
      chk("nop", '0, {ACC_WE, FILE_WB.we, Z_WE, PC_WE, FLUSH});
    end
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end

  // main sequence: reset, corner cases, then random back-to-back traffic
  initial
  begin
    RSTN = 1'b0;
    ISSUE = 1'b0;
    INSTR = '0;
    FILE_DATA = 8'h00;
    STATUS_IN = 8'h00;
    ACC_IN = 8'h00;
    n_mismatch = 0;
    num_checks = 0;
    lfsr = 32'h9277C123;
    repeat (2) @(negedge MCLK);
    chk("reset", '0, {ACC_WE, FILE_WB.we, Z_WE, PC_WE, FLUSH});
    RSTN = 1'b1;
    run(IDX_DEC_SKIP, 1'b0, 5'h03, 9'h000, 8'h01, 8'h00, 8'h00);
    run(IDX_INC_SKIP, 1'b1, 5'h1F, 9'h000, 8'hFF, 8'h00, 8'h00);
    run(IDX_INC_SKIP, 1'b0, 5'h00, 9'h000, 8'h05, 8'h00, 8'h00);
    run(IDX_DEC_SKIP, 1'b1, 5'h07, 9'h000, 8'h00, 8'h00, 8'h00);
    run(IDX_DEC_REG, 1'b1, 5'h00, 9'h000, 8'h00, 8'h00, 8'h00);
    run(IDX_DEC_REG, 1'b0, 5'h11, 9'h000, 8'h01, 8'h00, 8'h00);
    run(IDX_INC_REG, 1'b0, 5'h02, 9'h000, 8'hFF, 8'h00, 8'h00);
    run(IDX_OR_LIT, 1'b1, 5'h00, 9'h100, 8'hAA, 8'h00, 8'h00);
    run(IDX_OR_REG, 1'b1, 5'h1E, 9'h000, 8'h00, 8'h00, 8'h00);
    run(IDX_JUMP, 1'b0, 5'h00, 9'h1A5, 8'h00, 8'h40, 8'h00);
    run(IDX_JUMP, 1'b1, 5'h00, 9'h1FF, 8'h00, 8'h9F, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 300; i++)
    begin
      lfsr = nxt(lfsr);
      lfsr = nxt(lfsr);
      // the nop slot in the enum is swapped for a jump to keep traffic useful
      run((lfsr[2:0] == 3'h0) ? IDX_JUMP : idx_op_t'(lfsr[2:0]), lfsr[3],
        lfsr[8:4], lfsr[17:9], lfsr[31:24], lfsr[23:16], lfsr[15:8]);
    end
    ISSUE = 1'b0;
    $display("test random done");
    end_sim;
  end
endmodule
`default_nettype wire
